// >>> src/frame_if.sv
// Interface carrying frames and status words between the serial shifter and the core.
`timescale 1ns/100ps
`default_nettype none
interface frame_if;
  import hex_driver_pkg::*;
  word_t frame_word;
  logic  frame_toggle;
  word_t status_word;
  logic  thermal_bit;
  logic  shifter_clear;
  modport shifter (output frame_word, output frame_toggle, input status_word, input thermal_bit,
                   input shifter_clear);
  modport core    (input frame_word, input frame_toggle, output status_word, output thermal_bit,
                   output shifter_clear);
endinterface : frame_if
`default_nettype wire

// >>> src/hex_bridge_ctrl.sv
// Control and protection core of the twelve-switch half-bridge driver.
`timescale 1ns/100ps
`default_nettype none
module hex_bridge_ctrl
  import hex_driver_pkg::*;
(
  input  wire logic                               clk_in,
  input  wire logic                               nrst_in,
  input  wire logic                               sleep_n_in,
  input  wire logic                               logic_supply_ok_in,
  input  wire logic                               undervoltage_lockout_in,
  input  wire logic                               driver_supply_a_ov_in,
  input  wire logic                               driver_supply_b_ov_in,
  input  wire logic [hex_driver_pkg::NUM_SWITCHES-1:0] overcurrent_in,
  input  wire logic [hex_driver_pkg::NUM_SWITCHES-1:0] underload_in,
  input  wire logic [hex_driver_pkg::NUM_SENSORS-1:0]  thermal_warn_in,
  input  wire logic [hex_driver_pkg::NUM_SENSORS-1:0]  thermal_shutdown_in,
  input  wire logic                               sclk_in,
  input  wire logic                               chip_select_n_in,
  input  wire logic                               sdi_in,
  output logic                                    sdo_out,
  output logic                                    sdo_oe_out,
  output logic [hex_driver_pkg::NUM_SWITCHES-1:0] switch_on_out,
  output logic                                    overload_flag_out,
  output logic                                    underload_flag_out,
  output logic                                    supply_fault_flag_out,
  output logic                                    thermal_warning_flag_out
);
  import hex_driver_pkg::*;

  frame_if link ();

  serial_shifter u_shifter (
    .sclk_in          (sclk_in),
    .chip_select_n_in (chip_select_n_in),
    .sdi_in           (sdi_in),
    .sdo_out          (sdo_out),
    .sdo_oe_out       (sdo_oe_out),
    .link             (link.shifter)
  );

  // ==========================================================
  // Pin synchronisers: three flops, a change counts once stages two and three agree.
  // One chain per group keeps supply, overcurrent, underload and thermal paths apart for timing.
  function automatic sw_t settle(input sw_t second, input sw_t third, input sw_t held);
    return (third & ~(second ^ third)) | (held & (second ^ third));
  endfunction : settle

  // Supply and mode levels: sleep, logic supply, driver undervoltage, two overvoltages.
  logic [4:0] sup_s1;
  logic [4:0] sup_s2;
  logic [4:0] sup_s3;
  logic [4:0] sup_f;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sup_s1 <= 5'h00;
      sup_s2 <= 5'h00;
      sup_s3 <= 5'h00;
    end else begin
      sup_s1 <= {sleep_n_in, logic_supply_ok_in, undervoltage_lockout_in,
                 driver_supply_a_ov_in, driver_supply_b_ov_in};
      sup_s2 <= sup_s1;
      sup_s3 <= sup_s2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sup_f <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (sup_s2[i] == sup_s3[i]) begin
          sup_f[i] <= sup_s3[i];
        end
      end
    end
  end

  // Per-switch overcurrent levels.
  sw_t oc_s1;
  sw_t oc_s2;
  sw_t oc_s3;
  sw_t oc_f;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      oc_s1 <= SWITCH_RESET;
      oc_s2 <= SWITCH_RESET;
      oc_s3 <= SWITCH_RESET;
    end else begin
      oc_s1 <= overcurrent_in;
      oc_s2 <= oc_s1;
      oc_s3 <= oc_s2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      oc_f <= SWITCH_RESET;
    end else begin
      oc_f <= settle(oc_s2, oc_s3, oc_f);
    end
  end

  // Per-switch underload levels.
  sw_t ul_s1;
  sw_t ul_s2;
  sw_t ul_s3;
  sw_t ul_f;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ul_s1 <= SWITCH_RESET;
      ul_s2 <= SWITCH_RESET;
      ul_s3 <= SWITCH_RESET;
    end else begin
      ul_s1 <= underload_in;
      ul_s2 <= ul_s1;
      ul_s3 <= ul_s2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ul_f <= SWITCH_RESET;
    end else begin
      ul_f <= settle(ul_s2, ul_s3, ul_f);
    end
  end

  // Thermal levels: warnings in the upper half, shutdowns in the lower half.
  sw_t th_s1;
  sw_t th_s2;
  sw_t th_s3;
  sw_t th_f;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      th_s1 <= SWITCH_RESET;
      th_s2 <= SWITCH_RESET;
      th_s3 <= SWITCH_RESET;
    end else begin
      th_s1 <= {thermal_warn_in, thermal_shutdown_in};
      th_s2 <= th_s1;
      th_s3 <= th_s2;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      th_f <= SWITCH_RESET;
    end else begin
      th_f <= settle(th_s2, th_s3, th_f);
    end
  end

  logic                  awake;
  logic                  vcc_ok;
  logic                  drv_uv;
  logic                  ov_any;
  sw_t                   oc;
  sw_t                   ul;
  logic [NUM_SENSORS-1:0] tw;
  logic [NUM_SENSORS-1:0] tsd;
  assign {awake, vcc_ok, drv_uv} = sup_f[4:2];
  assign ov_any = sup_f[1] | sup_f[0];
  assign oc  = oc_f;
  assign ul  = ul_f;
  assign tw  = th_f[2*NUM_SENSORS-1:NUM_SENSORS];
  assign tsd = th_f[NUM_SENSORS-1:0];

  // ==========================================================
  // Frame event crossing: toggle through three flops, pulse when stages agree and differ from last.
  logic tg1;
  logic tg2;
  logic tg3;
  logic tg_seen;
  logic frame_evt;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tg1     <= 1'b0;
      tg2     <= 1'b0;
      tg3     <= 1'b0;
      tg_seen <= 1'b0;
    end else begin
      tg1 <= link.frame_toggle;
      tg2 <= tg1;
      tg3 <= tg2;
      if (tg2 == tg3) tg_seen <= tg3;
    end
  end
  assign frame_evt = (tg2 == tg3) && (tg3 != tg_seen);

  // The serial side has no reset of its own; this holds its frame toggle clear during reset.
  logic link_clear;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      link_clear <= 1'b1;
    end else begin
      link_clear <= 1'b0;
    end
  end
  assign link.shifter_clear = link_clear;

  // The frame word is stable long before the toggle is seen, so sampling it here is safe.
  word_t cmd;
  logic  srr_evt;
  logic  run;
  assign run     = awake && vcc_ok;
  assign srr_evt = frame_evt && run && link.frame_word[BIT_STATUS_RST];

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      cmd <= CMD_RESET;
    end else if (frame_evt) begin
      cmd <= link.frame_word;
    end
  end

  sw_t sel;
  logic oc_en;
  logic ul_en;
  logic ov_en;
  assign sel   = cmd[BIT_SW_HI:BIT_SW_LO];
  assign oc_en = cmd[BIT_OC_EN];
  assign ul_en = cmd[BIT_UL_EN];
  assign ov_en = cmd[BIT_OV_EN];

  // ==========================================================
  // Fault latches: set wins over status reset.
  sw_t  latched_off;
  logic f_oc;
  logic f_ul;
  logic f_ov;
  logic f_tw;
  sw_t  active;

  sw_t  oc_trip;
  sw_t  ul_trip;

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      oc_trip <= SWITCH_RESET;
    end else begin
      for (int i = 0; i < NUM_SWITCHES; i++) begin
        if (active[i] && oc[i] && oc_en) begin
          oc_trip[i] <= 1'b1;
        end else if (srr_evt) begin
          oc_trip[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      ul_trip <= SWITCH_RESET;
    end else begin
      for (int i = 0; i < NUM_SWITCHES; i++) begin
        if (active[i] && ul[i] && ul_en) begin
          ul_trip[i] <= 1'b1;
        end else if (srr_evt) begin
          ul_trip[i] <= 1'b0;
        end
      end
    end
  end

  assign latched_off = oc_trip | ul_trip;

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      f_oc <= 1'b0;
    end else if (|(oc & active)) begin
      f_oc <= 1'b1;
    end else if (srr_evt) begin
      f_oc <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      f_ul <= 1'b0;
    end else if (|(ul & active)) begin
      f_ul <= 1'b1;
    end else if (srr_evt) begin
      f_ul <= 1'b0;
    end
  end

  // Undervoltage also counts as a supply failure in the status word.
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      f_ov <= 1'b0;
    end else if (ov_any || drv_uv) begin
      f_ov <= 1'b1;
    end else if (srr_evt) begin
      f_ov <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      f_tw <= 1'b0;
    end else if (|tw) begin
      f_tw <= 1'b1;
    end else if (srr_evt) begin
      f_tw <= 1'b0;
    end
  end

  // ==========================================================
  // Switch drive: selections are kept; faults only gate the outputs.
  logic global_off;
  assign global_off = drv_uv || (|tsd) || (ov_en && ov_any);
  assign active     = sel & ~latched_off;

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      switch_on_out <= SWITCH_RESET;
    end else begin
      switch_on_out <= global_off ? SWITCH_RESET : active;
    end
  end

  assign overload_flag_out        = f_oc;
  assign underload_flag_out       = f_ul;
  assign supply_fault_flag_out    = f_ov;
  assign thermal_warning_flag_out = f_tw;

  // ==========================================================
  // Status snapshot; the shifter captures it once, at the fall of select, and holds it for the frame.
  word_t status;
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !run) begin
      status <= CMD_RESET;
    end else begin
      status[BIT_THERMAL]          <= f_tw;
      status[BIT_SW_HI:BIT_SW_LO]  <= switch_on_out;
      status[BIT_OVERLOAD]         <= f_oc;
      status[BIT_UNDERLOAD]        <= f_ul;
      status[BIT_SUPPLY]           <= f_ov;
    end
  end
  assign link.status_word = status;
  assign link.thermal_bit = f_tw;
endmodule : hex_bridge_ctrl
`default_nettype wire

// >>> src/hex_driver_pkg.sv
// Package with constants and types shared by the half-bridge control logic.
package hex_driver_pkg;
  localparam int FRAME_BITS     = 16;
  localparam int NUM_SWITCHES   = 12;
  localparam int NUM_SENSORS    = 6;
  localparam int BIT_STATUS_RST = 0;
  localparam int BIT_SW_LO      = 1;
  localparam int BIT_SW_HI      = 12;
  localparam int BIT_OC_EN      = 13;
  localparam int BIT_UL_EN      = 14;
  localparam int BIT_OV_EN      = 15;
  localparam int BIT_THERMAL    = 0;
  localparam int BIT_OVERLOAD   = 13;
  localparam int BIT_UNDERLOAD  = 14;
  localparam int BIT_SUPPLY     = 15;
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam logic [11:0] SWITCH_RESET = 12'h000;
  localparam int SYNC_STAGES    = 3;
  typedef logic [FRAME_BITS-1:0]   word_t;
  typedef logic [NUM_SWITCHES-1:0] sw_t;
endpackage : hex_driver_pkg

// >>> src/serial_shifter.sv
// Serial shift logic on the serial clock: frame capture, validity check and status shift-out.
`timescale 1ns/100ps
`default_nettype none
module serial_shifter
  import hex_driver_pkg::*;
(
  input  wire logic sclk_in,
  input  wire logic chip_select_n_in,
  input  wire logic sdi_in,
  output logic      sdo_out,
  output logic      sdo_oe_out,
  frame_if.shifter  link
);
  word_t      shift_in;
  word_t      shift_out;
  word_t      snap;
  logic [3:0] bit_cnt;
  logic       any_bits;
  logic       toggle;
  logic       cs_q;

  // ==========================================================
  // Input shift on falling serial clock.
  always_ff @(negedge sclk_in) begin
    if (!chip_select_n_in) begin
      shift_in <= {sdi_in, shift_in[FRAME_BITS-1:1]};
    end
  end

  always_ff @(negedge sclk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      bit_cnt  <= 4'h0;
      any_bits <= 1'b0;
    end else begin
      bit_cnt  <= bit_cnt + 4'h1;
      any_bits <= 1'b1;
    end
  end

  // Frame is transferred only on whole multiples of sixteen bits.
  // The core clears the toggle while it is in reset, so both ends of the crossing start equal.
  always_ff @(posedge chip_select_n_in or posedge link.shifter_clear) begin
    if (link.shifter_clear) begin
      link.frame_word <= CMD_RESET;
      toggle          <= 1'b0;
    end else if (any_bits && bit_cnt == 4'h0) begin
      link.frame_word <= shift_in;
      toggle          <= ~toggle;
    end
  end
  assign link.frame_toggle = toggle;

  // ==========================================================
  // Output: the core's status word is frozen at select fall and shifted out on rising clock.
  // A flag set while a frame runs therefore shows in the next frame.
  always_ff @(negedge chip_select_n_in) begin
    snap <= link.status_word;
  end

  always_ff @(posedge sclk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      cs_q <= 1'b0;
    end else begin
      cs_q <= 1'b1;
    end
  end

  always_ff @(posedge sclk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      shift_out <= CMD_RESET;
    end else if (!cs_q) begin
      shift_out <= {shift_in[0], snap[FRAME_BITS-1:1]};
    end else begin
      shift_out <= {shift_in[0], shift_out[FRAME_BITS-1:1]};
    end
  end

  // Bit 0 is the live latched warning until the first clock, so it shows at once.
  assign sdo_out    = cs_q ? shift_out[0] : link.thermal_bit;
  assign sdo_oe_out = ~chip_select_n_in;
endmodule : serial_shifter
`default_nettype wire

// >>> verif/hex_bridge_ctrl_bench.sv
// Self-checking bench for the half-bridge control core.
`timescale 1ns/100ps
`default_nettype none
module hex_bridge_ctrl_bench;
  import hex_driver_pkg::*;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        sleep_n = 1'b1;
  logic        ls_ok = 1'b1;
  logic        uv = 1'b0;
  logic        ova = 1'b0;
  logic        ovb = 1'b0;
  sw_t         oc = 12'h000;
  sw_t         ul = 12'h000;
  logic [5:0]  warn = 6'h00;
  logic [5:0]  ts = 6'h00;
  logic        sclk, csn, sdi, sdo, sdo_oe, ol, ulf, supply_fault_flag, tw, last_so, so_line;
  sw_t         sw;
  word_t       rd;
  int          checks = 0;
  int          fails = 0;
  int          cycles = 0;
  always #2.5 clk_in = ~clk_in;
  // A released serial out shows the inverse of its last bit, so a stale value never passes.
  always @(sdo or sdo_oe) if (sdo_oe) last_so = sdo;
  assign so_line = sdo_oe ? sdo : ~last_so;
  hex_bridge_ctrl i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .sleep_n_in(sleep_n), .logic_supply_ok_in(ls_ok),
    .undervoltage_lockout_in(uv), .driver_supply_a_ov_in(ova), .driver_supply_b_ov_in(ovb),
    .overcurrent_in(oc), .underload_in(ul), .thermal_warn_in(warn), .thermal_shutdown_in(ts),
    .sclk_in(sclk), .chip_select_n_in(csn), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .switch_on_out(sw), .overload_flag_out(ol), .underload_flag_out(ulf),
    .supply_fault_flag_out(supply_fault_flag), .thermal_warning_flag_out(tw));
  spi_host_model i_host (.sclk_out(sclk), .chip_select_n_out(csn), .sdi_out(sdi), .sdo_in(so_line));
  // ==========
  // Shared tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wt
  task automatic snd(input logic [31:0] w, input int n);
    i_host.xfer(w, n, rd);
    wt(1);
  endtask : snd
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      stop_test();
    end
  end
  // ==========
  // Scenarios
  task automatic t_reset;
    chk("switches", 16'h0000, sw);
    chk("flags", 16'h0000, {ol, ulf, supply_fault_flag, tw});
    chk("so_enable", 16'h0000, sdo_oe);
  endtask : t_reset
  task automatic t_cmd;
    snd(32'h0000_0aaa, 16);
    chk("switches", 16'h0555, sw);
    snd(32'h0000_1554, 16);
    chk("status", 16'h0aaa, rd);
    chk("switches", 16'h0aaa, sw);
    snd(32'h0000_0000, 12);
    chk("switches", 16'h0aaa, sw);
    snd(32'h0aaa_1554, 32);
    chk("switches", 16'h0555, sw);
  endtask : t_cmd
  task automatic t_oc;
    snd(32'h0000_2002, 16);
    oc = 12'h001;
    wt(12);
    chk("overload", 16'h0001, ol);
    chk("switches", 16'h0000, sw);
    oc = 12'h000;
    wt(12);
    chk("switches", 16'h0000, sw);
    snd(32'h0000_2003, 16);
    chk("status", 16'h2000, rd);
    chk("overload", 16'h0000, ol);
    chk("switches", 16'h0001, sw);
    snd(32'h0000_0002, 16);
    oc = 12'h001;
    wt(12);
    chk("overload", 16'h0001, ol);
    chk("switches", 16'h0001, sw);
    oc = 12'h000;
    snd(32'h0000_4003, 16);
    ul = 12'h001;
    wt(12);
    chk("underload", 16'h0001, ulf);
    chk("switches", 16'h0000, sw);
    ul = 12'h000;
    snd(32'h0000_0003, 16);
    chk("status", 16'h4000, rd);
    chk("switches", 16'h0001, sw);
  endtask : t_oc
  task automatic t_ov;
    snd(32'h0000_8002, 16);
    ova = 1'b1;
    wt(12);
    chk("switches", 16'h0000, sw);
    chk("supply_fault", 16'h0001, supply_fault_flag);
    ova = 1'b0;
    wt(12);
    chk("switches", 16'h0001, sw);
    chk("supply_fault", 16'h0001, supply_fault_flag);
    snd(32'h0000_0003, 16);
    ovb = 1'b1;
    wt(12);
    chk("switches", 16'h0001, sw);
    chk("supply_fault", 16'h0001, supply_fault_flag);
    ovb = 1'b0;
    snd(32'h0000_0003, 16);
    chk("supply_fault", 16'h0000, supply_fault_flag);
  endtask : t_ov
  task automatic t_thermal;
    warn = 6'h04;
    wt(12);
    chk("warning", 16'h0001, tw);
    chk("switches", 16'h0001, sw);
    warn = 6'h00;
    wt(12);
    snd(32'h0000_0002, 16);
    chk("status", 16'h0003, rd);
    ts = 6'h20;
    wt(12);
    chk("switches", 16'h0000, sw);
    snd(32'h0000_000a, 16);
    chk("switches", 16'h0000, sw);
    ts = 6'h00;
    wt(12);
    chk("switches", 16'h0005, sw);
    snd(32'h0000_000b, 16);
    chk("warning", 16'h0000, tw);
  endtask : t_thermal
  task automatic t_power;
    uv = 1'b1;
    wt(12);
    chk("switches", 16'h0000, sw);
    uv = 1'b0;
    wt(12);
    chk("switches", 16'h0005, sw);
    sleep_n = 1'b0;
    wt(12);
    sleep_n = 1'b1;
    wt(12);
    chk("switches", 16'h0000, sw);
    ls_ok = 1'b0;
    snd(32'h0000_0002, 16);
    chk("switches", 16'h0000, sw);
    ls_ok = 1'b1;
    wt(12);
    snd(32'h0000_0002, 16);
    chk("switches", 16'h0001, sw);
  endtask : t_power
  initial begin
    wt(10);
    nrst_in = 1'b1;
    wt(6);
    t_reset();
    t_cmd();
    t_oc();
    t_ov();
    t_thermal();
    t_power();
    stop_test();
  end
endmodule : hex_bridge_ctrl_bench
`default_nettype wire

// >>> verif/hex_bridge_ctrl_monitor.sv
// Checker on the ports of the half-bridge control core.
`timescale 1ns/100ps
`default_nettype none
module hex_bridge_ctrl_monitor
(
  input wire logic                                    clk_in,
  input wire logic                                    nrst_in,
  input wire logic                                    sleep_n_in,
  input wire logic                                    logic_supply_ok_in,
  input wire logic                                    driver_supply_a_ov_in,
  input wire logic                                    driver_supply_b_ov_in,
  input wire logic [hex_driver_pkg::NUM_SWITCHES-1:0] overcurrent_in,
  input wire logic [hex_driver_pkg::NUM_SENSORS-1:0]  thermal_shutdown_in,
  input wire logic                                    chip_select_n_in,
  input wire logic                                    sdo_out,
  input wire logic                                    sdo_oe_out,
  input wire logic [hex_driver_pkg::NUM_SWITCHES-1:0] switch_on_out,
  input wire logic                                    overload_flag_out,
  input wire logic                                    supply_fault_flag_out,
  input wire logic                                    thermal_warning_flag_out
);
  import hex_driver_pkg::*;
  // ==========
  // Cycles since the last event that may legally clear a flag
  logic [4:0] age;
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !sleep_n_in || !logic_supply_ok_in || $rose(chip_select_n_in)) age <= 5'h00;
    else if (age != 5'h1f) age <= age + 5'h01;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_oe; sdo_oe_out == !chip_select_n_in; endproperty
  a_oe: assert property (p_oe) else $error("serial out enable wrong");
  property p_tw_out;
    $fell(chip_select_n_in) && $past(thermal_warning_flag_out, 4) == thermal_warning_flag_out
      |-> sdo_out == thermal_warning_flag_out;
  endproperty
  a_tw_out: assert property (p_tw_out) else $error("warning not on serial out");
  property p_tw_hold; $fell(thermal_warning_flag_out) |-> age <= 5'd12; endproperty
  a_tw_hold: assert property (p_tw_hold) else $error("warning flag lost");
  property p_oc_hold; $fell(overload_flag_out) |-> age <= 5'd12; endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("overload flag lost");
  property p_sleep; !sleep_n_in [*6] |-> switch_on_out == 12'h000 && !thermal_warning_flag_out; endproperty
  a_sleep: assert property (p_sleep) else $error("state kept in sleep");
  property p_ot; (thermal_shutdown_in != 6'h00) [*6] |-> switch_on_out == 12'h000; endproperty
  a_ot: assert property (p_ot) else $error("switch on in overtemperature");
  property p_psf;
    ((driver_supply_a_ov_in || driver_supply_b_ov_in) && sleep_n_in && logic_supply_ok_in) [*8]
      |-> supply_fault_flag_out;
  endproperty
  a_psf: assert property (p_psf) else $error("supply fault flag missing");
  property p_oc;
    ((overcurrent_in & switch_on_out) != 12'h000 && sleep_n_in) ##1 (overcurrent_in != 12'h000) [*7]
      |-> overload_flag_out;
  endproperty
  a_oc: assert property (p_oc) else $error("overload flag missing");
  c_oc: cover property ($rose(overload_flag_out));
  c_tw: cover property ($rose(thermal_warning_flag_out));
  c_frame: cover property ($rose(chip_select_n_in) ##8 switch_on_out != 12'h000);
endmodule : hex_bridge_ctrl_monitor
bind hex_bridge_ctrl hex_bridge_ctrl_monitor i_mon (
  .clk_in(clk_in), .nrst_in(nrst_in), .sleep_n_in(sleep_n_in), .logic_supply_ok_in(logic_supply_ok_in),
  .driver_supply_a_ov_in(driver_supply_a_ov_in), .driver_supply_b_ov_in(driver_supply_b_ov_in),
  .overcurrent_in(overcurrent_in), .thermal_shutdown_in(thermal_shutdown_in),
  .chip_select_n_in(chip_select_n_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
  .switch_on_out(switch_on_out), .overload_flag_out(overload_flag_out),
  .supply_fault_flag_out(supply_fault_flag_out), .thermal_warning_flag_out(thermal_warning_flag_out));
`default_nettype wire

// >>> verif/spi_host_model.sv
// Host serial master model: select, serial clock and data toward the driver.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
(
  output logic      sclk_out,
  output logic      chip_select_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  import hex_driver_pkg::*;
  initial begin
    sclk_out = 1'b0;
    chip_select_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // ==========
  // Frame transfer
  // The clock stands low outside frames; released data is inverted so a stale bit never looks valid.
  task automatic xfer(input logic [31:0] w, input int n, output word_t r);
    r = '0;
    chip_select_n_out = 1'b0;
    #30;
    for (int i = 0; i < n; i++) begin
      #3 sdi_out = w[i];
      if (i < FRAME_BITS) r[i] = sdo_in;
      #3 sclk_out = 1'b1;
      #6 sclk_out = 1'b0;
    end
    #30 chip_select_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #100;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire
